/* File: logic/byte_stream_prefix_framer.sv */
// unit prefix framer: escaping encoder and aligning, stripping decoder
`timescale 1ns/1ps
`include "framer_defines.svh"
module byte_stream_prefix_framer (
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  // encoder: raw payload in, framed escaped stream out
  input  wire logic                 enc_in_valid,
  output logic                      enc_in_ready,
  input  wire framer_pkg::enc_in_t  enc_in,
  output logic                      enc_out_valid,
  input  wire logic                 enc_out_ready,
  output logic [7:0]                enc_out_data,
  // decoder inputs: serial bits or whole bytes
  input  wire logic                 dec_byte_mode,
  input  wire logic                 dec_restart,
  input  wire logic                 ser_valid,
  input  wire logic                 ser_bit,
  input  wire logic                 byte_valid,
  input  wire logic [7:0]           byte_data,
  output logic                      dec_in_ready,
  // decoder outputs
  output logic                      dec_out_valid,
  input  wire logic                 dec_out_ready,
  output framer_pkg::dec_out_t      dec_out,
  output logic                      dec_aligned,
  output logic                      pfx_seen,
  output logic                      pfx_long
);
  import framer_pkg::*;

  framer_state_t s_q;
  framer_state_t s_d;
  logic          enc_push;
  logic [7:0]    enc_byte;
  logic          enc_buf_ready;
  logic          dec_push;
  dec_out_t      dec_word;
  logic          dec_buf_ready;
  logic          byte_take;
  logic [7:0]    b;
  logic [15:0]   win;
  logic          bit_take;

  function automatic logic is_small(input logic [7:0] v);
    return (v[`FR_SMALL_MSB:`FR_SMALL_LSB] == 6'h00);
  endfunction : is_small

  function automatic logic is_fill(input logic [7:0] v);
    return (v == `FR_FILL_BYTE);
  endfunction : is_fill

  assign dec_in_ready = dec_buf_ready && !s_q.held;
  assign dec_aligned  = s_q.aligned;
  assign pfx_seen     = s_q.pfx_pulse;
  assign pfx_long     = s_q.pfx_long;
  assign bit_take     = !dec_byte_mode && ser_valid && dec_in_ready;
  assign win          = {s_q.sr[14:0], ser_bit};

  always_comb begin
    s_d           = s_q;
    s_d.pfx_pulse = 1'b0;
    enc_push      = 1'b0;
    enc_byte      = `FR_FILL_BYTE;
    enc_in_ready  = 1'b0;
    dec_push      = 1'b0;
    dec_word      = '0;
    byte_take     = 1'b0;
    b             = byte_data;

    // ---------------- encoder ----------------
    unique case (s_q.est)
      E_DATA: begin
        if (enc_in_valid && enc_buf_ready) begin
          enc_push = 1'b1;
          if (enc_in.first && !s_q.pfx_done) begin
            enc_byte = `FR_FILL_BYTE;
            s_d.est  = enc_in.long_pfx ? E_ZERO1 : E_ONE;
          end else if (s_q.prev_zero && is_small(enc_in.data) && !s_q.esc_done) begin
            enc_byte     = `FR_ESC_BYTE;
            s_d.esc_done = 1'b1;
          end else begin
            enc_byte      = enc_in.data;
            enc_in_ready  = 1'b1;
            // zero history is cleared by each marker byte, so it never runs across payloads
            s_d.prev_zero = is_fill(enc_in.data);
            s_d.esc_done  = 1'b0;
            s_d.pfx_done  = 1'b0;
          end
        end
      end
      E_ZERO1: begin
        if (enc_buf_ready) begin
          enc_push = 1'b1;
          enc_byte = `FR_FILL_BYTE;
          s_d.est  = E_ONE;
        end
      end
      E_ONE: begin
        if (enc_buf_ready) begin
          enc_push      = 1'b1;
          enc_byte      = `FR_MARKER_BYTE;
          s_d.est       = E_DATA;
          s_d.pfx_done  = 1'b1;
          s_d.prev_zero = 1'b0;
        end
      end
    endcase

    // ---------------- decoder input ----------------
    if (dec_byte_mode) begin
      byte_take = byte_valid && dec_in_ready;
    end else if (bit_take) begin
      s_d.sr = {s_q.sr[22:0], ser_bit};
      if (!s_q.aligned) begin
        // fifteen zeros then a one means a fill byte followed by the marker, at any bit offset
        if (win == `FR_ALIGN_PAT) begin
          s_d.aligned    = 1'b1;
          s_d.bitcnt     = 3'h0;
          s_d.zrun       = 2'h0;
          s_d.pfx_pulse  = 1'b1;
          s_d.pfx_long   = is_fill(s_q.sr[22:15]);
          s_d.first_pend = 1'b1;
        end
      end else begin
        s_d.acc    = {s_q.acc[6:0], ser_bit};
        s_d.bitcnt = s_q.bitcnt + 3'h1;
        if (s_q.bitcnt == `FR_BITCNT_LAST) begin
          byte_take = 1'b1;
          b         = {s_q.acc[6:0], ser_bit};
        end
      end
    end

    // ---------------- byte classification ----------------
    if (s_q.held && dec_buf_ready) begin
      dec_push  = 1'b1;
      dec_word  = '{data: s_q.held_byte, first: s_q.first_pend};
      s_d.held  = 1'b0;
    end else if (byte_take) begin
      if (is_fill(b)) begin
        // extra fill octets simply saturate the run
        if (s_q.zrun != `FR_ZRUN_MAX) begin
          s_d.zrun = s_q.zrun + 2'h1;
        end
      end else if (s_q.zrun == 2'h0) begin
        dec_push = 1'b1;
        dec_word = '{data: b, first: s_q.first_pend};
      end else if (b == `FR_MARKER_BYTE) begin
        s_d.pfx_pulse  = 1'b1;
        s_d.pfx_long   = (s_q.zrun == `FR_ZRUN_MAX);
        s_d.zrun       = 2'h0;
        s_d.first_pend = 1'b1;
      end else if (b == `FR_ESC_BYTE) begin
        dec_push = 1'b1;
        dec_word = '{data: `FR_FILL_BYTE, first: s_q.first_pend};
        s_d.zrun = 2'h0;
      end else begin
        // 0x02 falls here as plain data
        dec_push      = 1'b1;
        dec_word      = '{data: `FR_FILL_BYTE, first: s_q.first_pend};
        s_d.held      = 1'b1;
        s_d.held_byte = b;
        s_d.zrun      = 2'h0;
      end
    end
    // only the first pushed byte after a prefix carries the mark, a held byte never does
    if (dec_push) begin
      s_d.first_pend = 1'b0;
    end

    // restart wins over this cycle's decoder state updates except pfx_long and held_byte; a byte pushed this cycle still enters the buffer
    if (dec_restart) begin
      s_d.aligned    = 1'b0;
      s_d.sr         = `FR_SR_RESET;
      s_d.bitcnt     = 3'h0;
      s_d.acc        = `FR_ACC_RESET;
      s_d.zrun       = 2'h0;
      s_d.held       = 1'b0;
      s_d.first_pend = 1'b0;
      s_d.pfx_pulse  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q     <= '0;
      s_q.est <= E_DATA;
      // all ones so a lone one bit after reset cannot fake alignment
      s_q.sr  <= `FR_SR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  two_entry_buffer #(.WIDTH(8)) u_enc_buf (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_valid  (enc_push),
    .in_ready  (enc_buf_ready),
    .in_data   (enc_byte),
    .out_valid (enc_out_valid),
    .out_ready (enc_out_ready),
    .out_data  (enc_out_data)
  );

  two_entry_buffer #(.WIDTH($bits(dec_out_t))) u_dec_buf (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_valid  (dec_push),
    .in_ready  (dec_buf_ready),
    .in_data   (dec_word),
    .out_valid (dec_out_valid),
    .out_ready (dec_out_ready),
    .out_data  (dec_out)
  );

  // ---------------- checks ----------------
  sequence s_long_start;
    s_q.est == E_DATA && enc_push && enc_in.first && enc_in.long_pfx && !s_q.pfx_done;
  endsequence

  property p_enc_long_prefix;
    @(posedge sys_clk) disable iff (!resetn)
    s_long_start |=> (s_q.est == E_ZERO1);
  endproperty
  a_enc_long_prefix: assert property (p_enc_long_prefix) else $error("long prefix lost a fill");

  property p_enc_marker;
    @(posedge sys_clk) disable iff (!resetn)
    (s_q.est == E_ONE && enc_push) |-> (enc_byte == 8'h01) ##1 (s_q.est == E_DATA && s_q.pfx_done);
  endproperty
  a_enc_marker: assert property (p_enc_marker) else $error("marker byte wrong");

  property p_enc_escape;
    @(posedge sys_clk) disable iff (!resetn)
    // a payload byte of 0x03 is pushed with ready high; only the inserted one is checked
    (enc_push && !enc_in_ready && enc_byte == 8'h03 && s_q.est == E_DATA)
      |=> (s_q.esc_done && s_q.prev_zero);
  endproperty
  a_enc_escape: assert property (p_enc_escape) else $error("escape without zero history");

  property p_enc_no_small_after_zero;
    @(posedge sys_clk) disable iff (!resetn)
    (enc_in_ready && enc_in_valid && is_small(enc_in.data) && s_q.prev_zero) |-> s_q.esc_done;
  endproperty
  a_enc_no_small_after_zero: assert property (p_enc_no_small_after_zero) else $error("missed escape");

  property p_dec_long;
    @(posedge sys_clk) disable iff (!resetn || dec_restart)
    (byte_take && !s_q.held && b == 8'h01 && s_q.zrun == 2'h2) |=> (pfx_seen && pfx_long);
  endproperty
  a_dec_long: assert property (p_dec_long) else $error("long prefix not flagged");

  property p_dec_short;
    @(posedge sys_clk) disable iff (!resetn || dec_restart)
    (byte_take && !s_q.held && b == 8'h01 && s_q.zrun == 2'h1) |=> (pfx_seen && !pfx_long);
  endproperty
  a_dec_short: assert property (p_dec_short) else $error("short prefix not flagged");

  property p_dec_drop_esc;
    @(posedge sys_clk) disable iff (!resetn || dec_restart)
    (byte_take && !s_q.held && b == 8'h03 && s_q.zrun != 2'h0) |=> (s_q.zrun == 2'h0 && !s_q.held);
  endproperty
  a_dec_drop_esc: assert property (p_dec_drop_esc) else $error("escape byte kept");

  property p_dec_fill_only_zero;
    @(posedge sys_clk) disable iff (!resetn || dec_restart)
    (byte_take && !s_q.held && !is_fill(b)) |=> (s_q.zrun == 2'h0);
  endproperty
  a_dec_fill_only_zero: assert property (p_dec_fill_only_zero) else $error("nonzero counted as fill");

  property p_dec_align;
    @(posedge sys_clk) disable iff (!resetn || dec_restart)
    (bit_take && !s_q.aligned && win == 16'h0001) |=> (dec_aligned && s_q.bitcnt == 3'h0 && pfx_seen);
  endproperty
  a_dec_align: assert property (p_dec_align) else $error("alignment not taken");

  property p_dec_restart;
    @(posedge sys_clk) disable iff (!resetn)
    dec_restart |=> (!dec_aligned && s_q.zrun == 2'h0 && !pfx_seen);
  endproperty
  a_dec_restart: assert property (p_dec_restart) else $error("restart left state");

  property p_dec_bytes_need_align;
    @(posedge sys_clk) disable iff (!resetn)
    byte_take |-> (dec_byte_mode || s_q.aligned);
  endproperty
  a_dec_bytes_need_align: assert property (p_dec_bytes_need_align) else $error("byte before alignment");
endmodule : byte_stream_prefix_framer

/* File: logic/framer_defines.svh */
// constants of the prefix framer: byte codes, patterns and reset values
`ifndef FRAMER_DEFINES_SVH
`define FRAMER_DEFINES_SVH

`define FR_FILL_BYTE     8'h00
`define FR_MARKER_BYTE   8'h01
`define FR_RSV_BYTE      8'h02
`define FR_ESC_BYTE      8'h03
`define FR_SMALL_MSB     7
`define FR_SMALL_LSB     2
`define FR_ALIGN_PAT     16'h0001
`define FR_SR_RESET      24'hffffff
`define FR_ACC_RESET     8'h00
`define FR_BITCNT_LAST   3'h7
`define FR_ZRUN_MAX      2'h2
`define FR_BUF_DEPTH     2

`endif

/* File: logic/framer_pkg.sv */
// types shared by the prefix framer and its testbench
package framer_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic       first;
    logic       long_pfx;
  } enc_in_t;

  typedef struct packed {
    logic [7:0] data;
    logic       first;
  } dec_out_t;

  typedef enum logic [1:0] {E_DATA, E_ZERO1, E_ONE} enc_state_t;

  typedef struct packed {
    enc_state_t est;
    logic       pfx_done;
    logic       prev_zero;
    logic       esc_done;
    logic       aligned;
    logic [23:0] sr;
    logic [2:0] bitcnt;
    logic [7:0] acc;
    logic [1:0] zrun;
    logic       held;
    logic [7:0] held_byte;
    logic       first_pend;
    logic       pfx_pulse;
    logic       pfx_long;
  } framer_state_t;

endpackage : framer_pkg

/* File: logic/two_entry_buffer.sv */
// two-entry valid/ready buffer
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  rd;
    logic [1:0]            cnt;
  } buf_state_t;

  buf_state_t s_q;
  buf_state_t s_d;
  logic       push;
  logic       pop;
  logic       wr;

  assign in_ready  = (s_q.cnt != 2'h2);
  assign out_valid = (s_q.cnt != 2'h0);
  assign out_data  = s_q.mem[s_q.rd];

  always_comb begin
    s_d  = s_q;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    wr   = s_q.rd ^ s_q.cnt[0];
    if (push) begin
      s_d.mem[wr] = in_data;
    end
    if (pop) begin
      s_d.rd = ~s_q.rd;
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  property p_buf_full_stalls;
    @(posedge sys_clk) disable iff (!resetn)
    (s_q.cnt == 2'h2 && !out_ready) |=> !in_ready;
  endproperty
  a_buf_full_stalls: assert property (p_buf_full_stalls) else $error("buffer took a word while full");

  property p_buf_keeps_word;
    @(posedge sys_clk) disable iff (!resetn)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data));
  endproperty
  a_buf_keeps_word: assert property (p_buf_keeps_word) else $error("stalled word changed");
endmodule : two_entry_buffer

/* File: dv/remote_sink.sv */
// partner model: far-end consumer of the framed stream, stalling at random
`timescale 1ns/1ps
module remote_sink (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       valid,
  input  wire logic [7:0] data,
  output logic            ready
);
  logic [15:0] lf_q;
  logic        hold_q;
  logic [7:0]  last_q;
  logic [7:0]  got[$];
  int          bad_cnt = 0;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lf_q <= 16'h1357;
      ready <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      lf_q <= {lf_q[14:0], lf_q[15] ^ lf_q[13] ^ lf_q[12] ^ lf_q[10]};
      // about one cycle in four stalls, enough to fill the buffer
      ready <= lf_q[0] | lf_q[3];
      // any byte accepted: fill and marker codes are not judged here
      if (valid === 1'b1 && ready) got.push_back(data);
      if (hold_q && data !== last_q) bad_cnt++;
      hold_q <= (valid === 1'b1) && !ready;
      last_q <= data;
    end
  end
endmodule : remote_sink

/* File: dv/byte_stream_prefix_framer_test.sv */
// self-checking bench: encoder escaping, round trip, byte and serial decode
`timescale 1ns/1ps
module byte_stream_prefix_framer_test;
  import framer_pkg::*;
  logic        sys_clk, resetn, enc_in_valid, enc_in_ready, enc_out_valid, enc_out_ready;
  logic        dec_byte_mode, dec_restart, ser_valid, ser_bit, byte_valid, dec_in_ready;
  logic        dec_out_valid, dec_aligned, pfx_seen, pfx_long;
  logic        dec_out_ready = 1'b0;
  logic [7:0]  enc_out_data, byte_data;
  enc_in_t     enc_in;
  dec_out_t    dec_out;
  int          error_cnt = 0;
  int          num_checks = 0;
  logic [15:0] lfsr;
  logic [15:0] rdy_lf = 16'h2b7a;
  logic [7:0]  exp_enc[$];
  logic [8:0]  exp_dec[$], dq[$];
  logic        exp_pfx[$], pq[$];

  byte_stream_prefix_framer dut (.sys_clk(sys_clk), .resetn(resetn),
    .enc_in_valid(enc_in_valid), .enc_in_ready(enc_in_ready), .enc_in(enc_in),
    .enc_out_valid(enc_out_valid), .enc_out_ready(enc_out_ready),
    .enc_out_data(enc_out_data), .dec_byte_mode(dec_byte_mode),
    .dec_restart(dec_restart), .ser_valid(ser_valid), .ser_bit(ser_bit),
    .byte_valid(byte_valid), .byte_data(byte_data), .dec_in_ready(dec_in_ready),
    .dec_out_valid(dec_out_valid), .dec_out_ready(dec_out_ready), .dec_out(dec_out),
    .dec_aligned(dec_aligned), .pfx_seen(pfx_seen), .pfx_long(pfx_long));
  remote_sink u_sink (.sys_clk(sys_clk), .resetn(resetn), .valid(enc_out_valid),
    .data(enc_out_data), .ready(enc_out_ready));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic need_esc(input logic prev_zero, input logic [7:0] d);
    return prev_zero && d[7:2] == 6'h00;
  endfunction : need_esc

  always @(posedge sys_clk) begin
    rdy_lf <= lfsr_next(rdy_lf);
    dec_out_ready <= rdy_lf[1] | rdy_lf[4];
    if (resetn === 1'b1 && dec_out_valid === 1'b1 && dec_out_ready === 1'b1)
      dq.push_back(dec_out);
    if (pfx_seen === 1'b1) pq.push_back(pfx_long);
  end

  task automatic chk_byte(input logic [8:0] g, input logic [8:0] e, input string what);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask : chk_byte

  task automatic chk_flag(input logic g, input logic e, input string what);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t %s flag %b exp %b", $time, what, g, e);
    end
  endtask : chk_flag

  // holds the request until ready is seen high at a falling edge, then returns at the next rising edge
  task automatic wait_rdy(input logic dec);
    int n = 0;
    @(negedge sys_clk);
    while ((dec ? dec_in_ready : enc_in_ready) !== 1'b1 && n < 100) begin
      n++;
      @(negedge sys_clk);
    end
    if (n >= 100) chk_flag(1'b0, 1'b1, "ready timeout");
    @(posedge sys_clk);
  endtask : wait_rdy

  task automatic enc_unit(input logic lp, input int len);
    logic [7:0] d;
    logic       pz;
    pz = 1'b0;
    exp_enc.push_back(8'h00);
    if (lp) exp_enc.push_back(8'h00);
    exp_enc.push_back(8'h01);
    exp_pfx.push_back(lp);
    for (int i = 0; i < len; i++) begin
      lfsr = lfsr_next(lfsr);
      d = lfsr[0] ? {6'h00, lfsr[2:1]} : lfsr[15:8];
      if (lfsr[4:3] == 2'b11) d = 8'h00;
      // a payload never ends in zero
      if (i == len - 1) d = d | 8'h80;
      if (need_esc(pz, d)) exp_enc.push_back(8'h03);
      exp_enc.push_back(d);
      exp_dec.push_back({d, i == 0});
      pz = (d == 8'h00);
      enc_in_valid <= 1'b1;
      enc_in <= '{data: d, first: i == 0, long_pfx: lp};
      wait_rdy(1'b0);
    end
  endtask : enc_unit

  task automatic run_dec(input logic [7:0] bs[$], input logic serial, input string name);
    int n = 0;
    dec_byte_mode <= !serial;
    dec_restart <= 1'b1;
    @(posedge sys_clk);
    dec_restart <= 1'b0;
    @(negedge sys_clk);
    if (serial) chk_flag(dec_aligned, 1'b0, name);
    @(posedge sys_clk);
    foreach (bs[i]) for (int b = 7; b >= 0; b--) begin
      if (serial) begin
        ser_valid <= 1'b1;
        ser_bit <= bs[i][b];
        wait_rdy(1'b1);
      end else if (b == 7) begin
        byte_valid <= 1'b1;
        byte_data <= bs[i];
        wait_rdy(1'b1);
      end
    end
    byte_valid <= 1'b0;
    ser_valid <= 1'b0;
    while (dq.size() < exp_dec.size() && n < 300) begin
      n++;
      @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
    chk_flag(dq.size() == exp_dec.size(), 1'b1, name);
    foreach (exp_dec[i]) if (i < dq.size()) chk_byte(dq[i], exp_dec[i], name);
    chk_flag(pq.size() == exp_pfx.size(), 1'b1, name);
    foreach (exp_pfx[i]) if (i < pq.size()) chk_flag(pq[i], exp_pfx[i], name);
    dq.delete();
    pq.delete();
    exp_dec.delete();
    exp_pfx.delete();
    $display("test %s done", name);
  endtask : run_dec

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    int n;
    {enc_in_valid, dec_restart, ser_valid, ser_bit, byte_valid} = '0;
    enc_in = '0;
    byte_data = 8'h00;
    dec_byte_mode = 1'b1;
    lfsr = 16'h2b7a;
    resetn = 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    // back-to-back units, stimulus alternates long and short prefixes
    for (int u = 0; u < 6; u++) enc_unit(u % 2 == 0, 4 + u);
    enc_in_valid <= 1'b0;
    n = 0;
    while (u_sink.got.size() < exp_enc.size() && n < 300) begin
      n++;
      @(posedge sys_clk);
    end
    chk_flag(u_sink.got.size() == exp_enc.size(), 1'b1, "enc count");
    foreach (exp_enc[i]) if (i < u_sink.got.size())
      chk_byte({1'b0, u_sink.got[i]}, {1'b0, exp_enc[i]}, "enc byte");
    chk_flag(u_sink.bad_cnt == 0, 1'b1, "enc out stable");
    $display("test encoder done");
    run_dec(exp_enc, 1'b0, "roundtrip");
    // extra fill octet, escape, reserved pair, short prefix
    exp_dec = '{{8'h41, 1'b1}, {8'h00, 1'b0}, {8'h05, 1'b0}, {8'h00, 1'b0},
                {8'h02, 1'b0}, {8'h33, 1'b1}};
    exp_pfx = '{1'b1, 1'b0};
    run_dec('{8'h00, 8'h00, 8'h00, 8'h01, 8'h41, 8'h00, 8'h03, 8'h05, 8'h00, 8'h02,
              8'h00, 8'h01, 8'h33}, 1'b0, "bytes");
    // serial: junk, alignment, then trailing zeros left in history
    exp_dec = '{{8'h9c, 1'b1}, {8'h00, 1'b0}, {8'h11, 1'b0}};
    exp_pfx = '{1'b1};
    run_dec('{8'ha5, 8'h00, 8'h00, 8'h01, 8'h9c, 8'h00, 8'h03, 8'h11, 8'h00, 8'h00},
            1'b1, "serial");
    chk_flag(dec_aligned, 1'b1, "aligned");
    // after restart the stale zeros must not make this prefix long
    exp_dec = '{{8'h77, 1'b1}};
    exp_pfx = '{1'b0};
    run_dec('{8'h00, 8'h01, 8'h77}, 1'b1, "restart");
    final_report();
  end
endmodule : byte_stream_prefix_framer_test
